// ### hw/lxu_defs.svh
/*
 * constants for the load extract unit: operation codes, exception codes,
 * address field positions and widths.
 * assumes it is included by bare name from the package and the design file.
 */
// What this block does
// RQ1 - right merge address names least-significant byte
// RQ2 - right merge fills low register bytes
// RQ3 - merge lanes from offset and byte order
// RQ4 - right merge byte counts per order
// RQ5 - left merge byte counts per order
// RQ6 - merge loads raise only listed exceptions
// RQ7 - indexed fp load adds two registers
// RQ8 - indexed fp load needs doubleword alignment
// RQ9 - indexed fp load may report coprocessor unusable
// RQ10 - signed half load sign-extends
// RQ11 - unsigned half load zero-extends
// RQ12 - half loads fault on odd address
// RQ13 - half lane select with order flags
// RQ14 - linked word load sign-extends word
// RQ15 - linked load completion sets link flag
// RQ16 - one sequence, new link replaces old
// RQ17 - linked load never fails remote store
// RQ18 - linked word needs word alignment
// RQ19 - linked word has no bus error
// RQ20 - left merge address names most-significant byte
// RQ21 - always fetch aligned doubleword, extract internally; halfword loads with the reverse flag set fetch with address bits 2:1 set
`ifndef LXU_DEFS_SVH
`define LXU_DEFS_SVH

`define LXU_OP_LEFT 3'h0
`define LXU_OP_RIGHT 3'h1
`define LXU_OP_FPIDX 3'h2
`define LXU_OP_HALF_S 3'h3
`define LXU_OP_HALF_U 3'h4
`define LXU_OP_LINKED 3'h5

`define LXU_EXC_NONE 3'h0
`define LXU_EXC_TLB_REFILL 3'h1
`define LXU_EXC_TLB_INVALID 3'h2
`define LXU_EXC_BUS_ERROR 3'h3
`define LXU_EXC_ADDR_ERROR 3'h4
`define LXU_EXC_RESERVED 3'h5
`define LXU_EXC_COP_UNUSABLE 3'h6

`define LXU_LANE_MSB 2
`define LXU_ALIGN_MASK_DW 3'h7
`define LXU_ALIGN_MASK_W 3'h3
`define LXU_ALIGN_MASK_H 3'h1
`define LXU_BYTE_BITS 3
`define LXU_BYTES 8
`define LXU_LANE_ZERO 3'h0

`endif

// ### hw/lxu_pkg.sv
/*
 * types for the load extract unit.
 * assumes lxu_defs.svh is on the include path.
 */
`include "lxu_defs.svh"

package lxu_pkg;

    typedef enum logic [1:0] {
        LXU_IDLE,
        LXU_WAIT,
        LXU_DONE
    } lxu_state_t;

    typedef struct packed {
        lxu_state_t state;
        logic [2:0] op;
        logic [63:0] vaddr;
        logic [63:0] old_value;
        logic big_endian;
        logic [4:0] dest;
        logic [63:0] result;
        logic [4:0] result_dest;
        logic result_gpr_we;
        logic result_fpr_we;
        logic [2:0] exc_code;
        logic exc_valid;
        logic link_flag;
        logic [63:0] link_addr;
        logic [63:0] mem_addr;
        logic mem_req;
    } lxu_regs_t;

endpackage

// ### hw/lxu_load_extract_unit.sv
/*
 * load extract unit: address formation, alignment check, doubleword fetch (aligned except
 * reversed halfword loads, which set address bits 2:1), byte lane selection, merging and extension for six load kinds.
 * assumes the pipeline holds req until req_ready, and the memory side answers
 * each mem_req with one mem_valid carrying the aligned doubleword or a fault.
 */
`timescale 1ns/1ps
`default_nettype none
`include "lxu_defs.svh"

module lxu_load_extract_unit (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [2:0] req_op,
    input wire logic [63:0] base_value,
    input wire logic [63:0] index_value,
    input wire logic [15:0] offset,
    input wire logic [63:0] target_value,
    input wire logic [4:0] target_register,
    input wire logic big_endian_core_flag,
    input wire logic reverse_byte_order_flag,
    input wire logic fp_usable,
    input wire logic op_implemented,
    input wire logic store_clears_link,
    output logic mem_req,
    output logic [63:0] mem_addr,
    input wire logic mem_valid,
    input wire logic [63:0] mem_data,
    input wire logic mem_tlb_refill,
    input wire logic mem_tlb_invalid,
    input wire logic mem_bus_error,
    output logic result_valid,
    output logic [63:0] result_value,
    output logic [4:0] result_dest,
    output logic result_gpr_we,
    output logic result_fpr_we,
    output logic exc_valid,
    output logic [2:0] exc_code,
    output logic link_flag,
    output logic [63:0] link_addr
);

    lxu_pkg::lxu_regs_t r;
    lxu_pkg::lxu_regs_t next_r;

    logic [63:0] sext_off;
    logic [63:0] eff_addr;
    logic misaligned;
    logic [2:0] k;
    logic [2:0] bsel;
    logic [15:0] half;
    logic [31:0] word;
    logic [63:0] merged;
    logic [2:0] src;
    integer i;
    logic is_half;
    logic [2:0] rev_lanes;

    assign sext_off = {{48{offset[15]}}, offset};

    // RQ13 reverse order flag flips lane bits of halfword fetches only
    assign is_half = (req_op == `LXU_OP_HALF_S) || (req_op == `LXU_OP_HALF_U);
    always_comb
    begin
        if (is_half)
        begin
            rev_lanes = {reverse_byte_order_flag, reverse_byte_order_flag, 1'b0};
        end
        else
        begin
            rev_lanes = `LXU_LANE_ZERO;
        end
    end

    // RQ7 indexed address sum
    always_comb
    begin
        if (req_op == `LXU_OP_FPIDX)
        begin
            eff_addr = base_value + index_value;
        end
        else
        begin
            eff_addr = base_value + sext_off;
        end
    end

    always_comb
    begin
        case (req_op)
            // RQ8 doubleword alignment
            `LXU_OP_FPIDX: misaligned = (eff_addr[2:0] & `LXU_ALIGN_MASK_DW) != `LXU_LANE_ZERO;
            // RQ12 halfword alignment
            `LXU_OP_HALF_S,
            `LXU_OP_HALF_U: misaligned = (eff_addr[2:0] & `LXU_ALIGN_MASK_H) != `LXU_LANE_ZERO;
            // RQ18 word alignment
            `LXU_OP_LINKED: misaligned = (eff_addr[2:0] & `LXU_ALIGN_MASK_W) != `LXU_LANE_ZERO;
            // RQ1 RQ20 merges take any byte boundary
            default: misaligned = 1'b0;
        endcase
    end

    assign k = r.vaddr[`LXU_LANE_MSB:0];
    // RQ13 lane for half and word, big-endian flips upper lane bits
    always_comb
    begin
        if (r.op == `LXU_OP_LINKED)
        begin
            bsel = k ^ {r.big_endian, 2'b00};
        end
        else
        begin
            bsel = k ^ {r.big_endian, r.big_endian, 1'b0};
        end
    end
    assign half = mem_data[(8 * bsel) +: 16];
    assign word = mem_data[(8 * bsel) +: 32];

    // RQ3 merge byte lanes from offset and byte order
    always_comb
    begin
        merged = r.old_value;
        src = `LXU_LANE_ZERO;
        for (i = 0; i < `LXU_BYTES; i = i + 1)
        begin
            src = 3'(i);
            if (r.op == `LXU_OP_LEFT)
            begin
                // RQ5 RQ20 left merge fills high bytes
                if (r.big_endian)
                begin
                    // offset k leaves the lowest k register bytes untouched
                    if (4'(i) + 4'(k) <= 4'h7)
                    begin
                        src = 3'(i) + k;
                        merged[8 * (7 - i) +: 8] = mem_data[8 * (7 - src) +: 8];
                    end
                end
                else if (3'(i) <= k)
                begin
                    merged[8 * (7 - i) +: 8] = mem_data[8 * (k - 3'(i)) +: 8];
                end
            end
            else
            begin
                // RQ2 RQ4 right merge fills low bytes
                if (r.big_endian)
                begin
                    if (3'(i) <= k)
                    begin
                        merged[8 * i +: 8] = mem_data[8 * (7 - (k - 3'(i))) +: 8];
                    end
                end
                else if (4'(i) + 4'(k) <= 4'h7)
                begin
                    // RQ1 offset names least-significant byte
                    merged[8 * i +: 8] = mem_data[8 * (3'(i) + k) +: 8];
                end
            end
        end
    end

    assign req_ready = (r.state == lxu_pkg::LXU_IDLE);

    always_comb
    begin
        next_r = r;
        next_r.result_gpr_we = 1'b0;
        next_r.result_fpr_we = 1'b0;
        next_r.exc_valid = 1'b0;
        next_r.exc_code = `LXU_EXC_NONE;
        // RQ17 only this core's store path clears the link
        if (store_clears_link)
        begin
            next_r.link_flag = 1'b0;
        end
        case (r.state)
            lxu_pkg::LXU_IDLE:
            begin
                if (req_valid)
                begin
                    next_r.op = req_op;
                    next_r.vaddr = eff_addr;
                    next_r.old_value = target_value;
                    next_r.big_endian = big_endian_core_flag;
                    next_r.dest = target_register;
                    next_r.result_dest = target_register;
                    if (!op_implemented || req_op > `LXU_OP_LINKED)
                    begin
                        next_r.exc_valid = 1'b1;
                        next_r.exc_code = `LXU_EXC_RESERVED;
                        next_r.state = lxu_pkg::LXU_DONE;
                    end
                    // RQ9 coprocessor unusable for fp load
                    else if (req_op == `LXU_OP_FPIDX && !fp_usable)
                    begin
                        next_r.exc_valid = 1'b1;
                        next_r.exc_code = `LXU_EXC_COP_UNUSABLE;
                        next_r.state = lxu_pkg::LXU_DONE;
                    end
                    // RQ8 RQ12 RQ18 fault before any memory access
                    else if (misaligned)
                    begin
                        next_r.exc_valid = 1'b1;
                        next_r.exc_code = `LXU_EXC_ADDR_ERROR;
                        next_r.state = lxu_pkg::LXU_DONE;
                    end
                    else
                    begin
                        // RQ21 aligned doubleword request, RQ13 reverse flag on lane bits
                        next_r.mem_addr = {eff_addr[63:3], `LXU_LANE_ZERO ^ rev_lanes};
                        next_r.mem_req = 1'b1;
                        next_r.state = lxu_pkg::LXU_WAIT;
                    end
                end
            end
            lxu_pkg::LXU_WAIT:
            begin
                if (mem_valid)
                begin
                    next_r.mem_req = 1'b0;
                    next_r.state = lxu_pkg::LXU_DONE;
                    if (mem_tlb_refill)
                    begin
                        next_r.exc_valid = 1'b1;
                        next_r.exc_code = `LXU_EXC_TLB_REFILL;
                    end
                    else if (mem_tlb_invalid)
                    begin
                        next_r.exc_valid = 1'b1;
                        next_r.exc_code = `LXU_EXC_TLB_INVALID;
                    end
                    // RQ6 RQ19 bus error only for merge loads and signed half
                    else if (mem_bus_error && (r.op == `LXU_OP_LEFT || r.op == `LXU_OP_RIGHT ||
                             r.op == `LXU_OP_HALF_S))
                    begin
                        next_r.exc_valid = 1'b1;
                        next_r.exc_code = `LXU_EXC_BUS_ERROR;
                    end
                    else
                    begin
                        case (r.op)
                            `LXU_OP_LEFT,
                            `LXU_OP_RIGHT: next_r.result = merged;
                            // RQ7 uninterpreted doubleword
                            `LXU_OP_FPIDX: next_r.result = mem_data;
                            // RQ10 sign-extend half
                            `LXU_OP_HALF_S: next_r.result = {{48{half[15]}}, half};
                            // RQ11 zero-extend half
                            `LXU_OP_HALF_U: next_r.result = {48'h0000_0000_0000, half};
                            // RQ14 sign-extend word
                            default: next_r.result = {{32{word[31]}}, word};
                        endcase
                        next_r.result_fpr_we = (r.op == `LXU_OP_FPIDX);
                        next_r.result_gpr_we = (r.op != `LXU_OP_FPIDX);
                        // RQ15 RQ16 set link, replacing any prior sequence
                        if (r.op == `LXU_OP_LINKED)
                        begin
                            next_r.link_flag = 1'b1;
                            next_r.link_addr = r.vaddr;
                        end
                    end
                end
            end
            lxu_pkg::LXU_DONE:
            begin
                next_r.state = lxu_pkg::LXU_IDLE;
            end
            default:
            begin
                next_r.state = lxu_pkg::LXU_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            r <= '0;
            r.state <= lxu_pkg::LXU_IDLE;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign mem_req = r.mem_req;
    assign mem_addr = r.mem_addr;
    assign result_valid = r.result_gpr_we | r.result_fpr_we;
    assign result_value = r.result;
    assign result_dest = r.result_dest;
    assign result_gpr_we = r.result_gpr_we;
    assign result_fpr_we = r.result_fpr_we;
    assign exc_valid = r.exc_valid;
    assign exc_code = r.exc_code;
    assign link_flag = r.link_flag;
    assign link_addr = r.link_addr;

endmodule
`default_nettype wire

// ### tb/lxu_mem_model.sv
/* memory side model: answers each mem_req with one mem_valid pulse.
   assumes mem_req holds until the edge that sees mem_valid. */
`timescale 1ns/1ps
`default_nettype none
module lxu_mem_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic mem_req,
    input wire logic [63:0] mem_dw,
    input wire logic [3:0] mem_wait,
    input wire logic [2:0] mem_flt,
    output logic mem_valid,
    output logic [63:0] mem_data,
    output logic mem_tlb_refill,
    output logic mem_tlb_invalid,
    output logic mem_bus_error
);
    logic [3:0] cnt;
    logic done;
    always_ff @(posedge clk)
    begin
        mem_valid <= 1'b0;
        if (!rst_b)
        begin
            cnt <= 4'h0;
            done <= 1'b0;
        end
        else if (!mem_req)
            done <= 1'b0;
        else if (!done && cnt == mem_wait)
        begin
            mem_valid <= 1'b1;
            done <= 1'b1;
            cnt <= 4'h0;
        end
        else if (!done)
            cnt <= cnt + 4'h1;
    end
    // data lines show the inverse outside the answer cycle
    assign mem_data = mem_valid ? mem_dw : ~mem_dw;
    assign {mem_bus_error, mem_tlb_invalid, mem_tlb_refill} = mem_valid ? mem_flt : 3'h0;
endmodule
`default_nettype wire

// ### tb/lxu_load_extract_unit_sva.sv
/* port assertions for the load extract unit.
   assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module lxu_load_extract_unit_sva (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [2:0] req_op,
    input wire logic [63:0] base_value,
    input wire logic [63:0] index_value,
    input wire logic [15:0] offset,
    input wire logic fp_usable,
    input wire logic op_implemented,
    input wire logic mem_req,
    input wire logic [63:0] mem_addr,
    input wire logic result_valid,
    input wire logic [63:0] result_value,
    input wire logic result_gpr_we,
    input wire logic result_fpr_we,
    input wire logic exc_valid,
    input wire logic [2:0] exc_code,
    input wire logic link_flag
);
    logic [2:0] last_op;
    logic take;
    logic [63:0] ea;
    logic [63:0] fea;
    assign take = req_valid && req_ready;
    assign ea = base_value + {{48{offset[15]}}, offset};
    assign fea = base_value + index_value;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            last_op <= 3'h0;
        else if (take)
            last_op <= req_op;
    end
    a_merge_addr: assert property (take && req_op <= 3'h1 && op_implemented
        |=> mem_req && mem_addr == {ea[63:3], 3'h0}) else $error("merge fetch address wrong");
    a_half_odd: assert property (take && (req_op == 3'h3 || req_op == 3'h4) && op_implemented && ea[0]
        |=> exc_valid && exc_code == 3'h4 && !mem_req) else $error("odd half address not refused");
    a_fp_align: assert property (take && req_op == 3'h2 && op_implemented && fp_usable && fea[2:0] != 3'h0
        |=> exc_valid && exc_code == 3'h4 && !mem_req) else $error("unaligned fp load not refused");
    a_link_set: assert property (result_valid && last_op == 3'h5
        |-> link_flag) else $error("link flag not set");
    a_fp_dest: assert property (result_valid && last_op == 3'h2
        |-> result_fpr_we && !result_gpr_we) else $error("fp load wrong write enable");
    a_half_sext: assert property (result_valid && last_op == 3'h3
        |-> result_value[63:16] == {48{result_value[15]}}) else $error("half not sign extended");
    a_half_zext: assert property (result_valid && last_op == 3'h4
        |-> result_value[63:16] == 48'h0) else $error("half not zero extended");
    a_word_sext: assert property (result_valid && last_op == 3'h5
        |-> result_value[63:32] == {32{result_value[31]}}) else $error("word not sign extended");
    a_no_bus: assert property (exc_valid && (last_op == 3'h2 || last_op == 3'h4 || last_op == 3'h5)
        |-> exc_code != 3'h3) else $error("bus error on load without it");
    a_merge_exc: assert property (exc_valid && last_op <= 3'h1
        |-> exc_code != 3'h6 && exc_code != 3'h0) else $error("merge load bad exception");
endmodule
bind lxu_load_extract_unit lxu_load_extract_unit_sva lxu_load_extract_unit_sva_i (.*);
`default_nettype wire

// ### tb/testbench.sv
/* self-checking bench for the load extract unit with a memory model.
   assumes the hand-over timing; inputs change at the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic [2:0] op;
        logic [3:0] md;
        logic [2:0] fl;
        logic [15:0] of;
        logic [63:0] b;
        logic [63:0] ix;
        logic [63:0] a;
        logic [63:0] v;
        logic [2:0] x;
    } lxu_row_t;
    logic clk, rst_b, req_valid, req_ready, big_endian_core_flag, reverse_byte_order_flag, fp_usable;
    logic op_implemented, store_clears_link, mem_req, mem_valid, mem_tlb_refill, mem_tlb_invalid;
    logic mem_bus_error, result_valid, result_gpr_we, result_fpr_we, exc_valid, link_flag;
    logic [2:0] req_op, exc_code, mem_flt, got_x;
    logic [3:0] mem_wait;
    logic [4:0] target_register, result_dest;
    logic [15:0] offset;
    logic [63:0] base_value, index_value, target_value, mem_addr, mem_data, result_value, link_addr;
    logic [63:0] mem_dw, got_v, got_a, e;
    int n_fail = 0, n_compared = 0, sh;
    // md is {big endian, reverse, fp usable, implemented}; a of zero means no fetch
    lxu_row_t rows [14] = '{
        '{3'h3, 4'hb, 3'h0, 16'h0004, 64'h1000, 64'h0, 64'h1000, 64'hffff_ffff_ffff_d566, 3'h0},
        '{3'h4, 4'hf, 3'h0, 16'h0004, 64'h1000, 64'h0, 64'h1006, 64'h0000_0000_0000_d566, 3'h0},
        '{3'h3, 4'h3, 3'h0, 16'hfffe, 64'h1010, 64'h0, 64'h1008, 64'h0000_0000_0000_11f2, 3'h0},
        '{3'h5, 4'h3, 3'h0, 16'h0000, 64'h2000, 64'h0, 64'h2000, 64'hffff_ffff_d566_7788, 3'h0},
        '{3'h2, 4'h3, 3'h0, 16'h0000, 64'h2000, 64'h8, 64'h2008, 64'h11f2_3344_d566_7788, 3'h0},
        '{3'h3, 4'h3, 3'h0, 16'h0001, 64'h1000, 64'h0, 64'h0, 64'h0, 3'h4},
        '{3'h5, 4'h3, 3'h0, 16'h0002, 64'h1000, 64'h0, 64'h0, 64'h0, 3'h4},
        '{3'h2, 4'h3, 3'h0, 16'h0000, 64'h1000, 64'h4, 64'h0, 64'h0, 3'h4},
        '{3'h2, 4'h1, 3'h0, 16'h0000, 64'h1000, 64'h8, 64'h0, 64'h0, 3'h6},
        '{3'h0, 4'h2, 3'h0, 16'h0000, 64'h1000, 64'h0, 64'h0, 64'h0, 3'h5},
        '{3'h0, 4'h3, 3'h4, 16'h0000, 64'h1000, 64'h0, 64'h1000, 64'h0, 3'h3},
        '{3'h5, 4'h3, 3'h4, 16'h0000, 64'h2000, 64'h0, 64'h2000, 64'hffff_ffff_d566_7788, 3'h0},
        '{3'h3, 4'h3, 3'h1, 16'h0000, 64'h1000, 64'h0, 64'h1000, 64'h0, 3'h1},
        '{3'h6, 4'h3, 3'h0, 16'h0000, 64'h1000, 64'h0, 64'h0, 64'h0, 3'h5}};
    lxu_load_extract_unit lxu_load_extract_unit_i (.*);
    lxu_mem_model lxu_mem_model_i (.*);
    always #12.5 clk = ~clk;
    task automatic chk(input string n, input logic [63:0] ex, input logic [63:0] g);
        n_compared++;
        if (g !== ex)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", n, ex, g);
        end
    endtask
    task automatic check_row(input lxu_row_t r);
        int i;
        while (req_ready !== 1'b1)
            @(negedge clk);
        {big_endian_core_flag, reverse_byte_order_flag, fp_usable, op_implemented} = r.md;
        {req_op, mem_flt, offset, base_value, index_value} = {r.op, r.fl, r.of, r.b, r.ix};
        target_register = {2'h1, r.op};
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        got_a = 64'h0;
        for (i = 0; i < 40 && result_valid !== 1'b1 && exc_valid !== 1'b1; i++)
        begin
            if (mem_req === 1'b1)
                got_a = mem_addr;
            @(negedge clk);
        end
        got_v = result_value;
        got_x = result_valid === 1'b1 ? 3'h0 : (exc_valid === 1'b1 ? exc_code : 3'h7);
        chk("fetch address", r.a, got_a);
        chk("exception", {61'h0, r.x}, {61'h0, got_x});
        if (r.x == 3'h0)
        begin
            chk("value", r.v, got_v);
            chk("destination", {59'h0, 2'h1, r.op}, {59'h0, result_dest});
            chk("fp write", {63'h0, r.op == 3'h2}, {63'h0, result_fpr_we});
            chk("general write", {63'h0, r.op != 3'h2}, {63'h0, result_gpr_we});
        end
    endtask
    task automatic complete_run;
        $display("compared %0d, mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // whole sequence needs under a thousand cycles
    initial
    begin
        #100000;
        n_fail++;
        complete_run;
    end
    initial
    begin
        {clk, rst_b, req_valid, store_clears_link, fp_usable, op_implemented} = 6'h3;
        {big_endian_core_flag, reverse_byte_order_flag, req_op, mem_flt, mem_wait} = '0;
        {offset, base_value, index_value, target_register} = '0;
        {target_value, mem_dw} = {64'ha1a2_a3a4_a5a6_a7a8, 64'h11f2_3344_d566_7788};
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        chk("ready", 1, req_ready);
        chk("link", 0, link_flag);
        $display("reset test done");
        foreach (rows[j])
            check_row(rows[j]);
        $display("table rows done");
        mem_wait = 4'h2;
        for (int m = 0; m < 32; m++)
        begin
            sh = (m[3] ^ m[4]) ? m % 8 : 7 - m % 8;
            e = m[4] ? (mem_dw >> 8 * sh) | (target_value & ~({64{1'b1}} >> 8 * sh))
                     : (mem_dw << 8 * sh) | (target_value & ~({64{1'b1}} << 8 * sh));
            check_row('{{2'h0, m[4]}, {m[3], 3'h3}, 3'h0, {13'h0, m[2:0]}, 64'h4000, 64'h0, 64'h4000, e, 3'h0});
        end
        $display("merge test done");
        store_clears_link = 1'b1;
        @(negedge clk);
        store_clears_link = 1'b0;
        chk("link cleared", 0, link_flag);
        mem_wait = 4'h5;
        check_row(rows[3]);
        check_row('{3'h5, 4'h3, 3'h0, 16'h0008, 64'h3000, 64'h0, 64'h3008, 64'hffff_ffff_d566_7788, 3'h0});
        chk("link set", 1, link_flag);
        chk("link address", 64'h3008, link_addr);
        $display("link test done");
        while (req_ready !== 1'b1)
            @(negedge clk);
        {req_op, base_value, offset, req_valid, mem_wait} = {3'h5, 64'h3000, 16'h0, 1'b1, 4'h8};
        @(negedge clk);
        req_valid = 1'b0;
        repeat (2) @(negedge clk);
        rst_b = 1'b0;
        @(negedge clk);
        chk("ready in reset", 1, req_ready);
        chk("fetch in reset", 0, mem_req);
        rst_b = 1'b1;
        check_row(rows[0]);
        $display("mid-run reset test done");
        complete_run;
    end
endmodule
`default_nettype wire
